// ==== include/ulfc_pkg.sv ====
// Package with register map, field positions and configuration types for the line format block.
package ulfc_pkg;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [4:0] ULFC_OFF_LFC    = 5'h00;
	localparam logic [4:0] ULFC_OFF_MLC    = 5'h04;
	localparam logic [4:0] ULFC_OFF_SYN    = 5'h08;
	localparam logic [4:0] ULFC_OFF_DLE    = 5'h0C;
	localparam logic [4:0] ULFC_OFF_STATUS = 5'h10;
	localparam logic [4:0] ULFC_OFF_MASK   = 5'h14;
	localparam logic [4:0] ULFC_OFF_RXDATA = 5'h18;

	// Values after reset.
	localparam logic [7:0] ULFC_RST_LFC  = 8'h00;
	localparam logic [7:0] ULFC_RST_MLC  = 8'h00;
	localparam logic [7:0] ULFC_RST_SYN  = 8'h16;
	localparam logic [7:0] ULFC_RST_DLE  = 8'h10;
	localparam logic [1:0] ULFC_RST_IRQ  = 2'h0;

	// Line format control field positions.
	localparam int ULFC_LFC_CLK_LO  = 0;
	localparam int ULFC_LFC_RXCLK   = 3;
	localparam int ULFC_LFC_ODD     = 4;
	localparam int ULFC_LFC_SYNC    = 5;
	localparam int ULFC_LFC_LEN_LO  = 6;

	// Modem link control field positions.
	localparam int ULFC_MLC_DTR     = 0;
	localparam int ULFC_MLC_RTS     = 1;
	localparam int ULFC_MLC_RXEN    = 2;
	localparam int ULFC_MLC_PAR     = 3;
	localparam int ULFC_MLC_ECHO    = 4;
	localparam int ULFC_MLC_STOP    = 5;
	localparam int ULFC_MLC_TRANSP  = 6;
	localparam int ULFC_MLC_NORMAL  = 7;

	// Status and mask bit positions.
	localparam int ULFC_IRQ_RXDATA  = 0;
	localparam int ULFC_IRQ_SYNDET  = 1;

	// Clock select codes for the external 1X clocks and the divide-by-two rate.
	localparam logic [2:0] ULFC_CLK_EXT1X = 3'h0;
	localparam logic [2:0] ULFC_CLK_DIV2  = 3'h5;

	// Stop bit choice for the transmitter.
	typedef enum logic [1:0] {
		ULFC_STOP_ONE,
		ULFC_STOP_ONE_HALF,
		ULFC_STOP_TWO
	} ulfc_stop_t;

	// Decoded configuration handed to the serial engines.
	typedef struct packed {
		logic [3:0] data_bits;
		logic       sync_mode;
		logic       loop_mode;
		logic       parity_odd;
		logic       tx_parity_en;
		logic       rx_parity_en;
		ulfc_stop_t stop_sel;
		logic       transparent;
		logic       force_dle;
		logic       tx_break;
		logic       echo;
		logic       rx_enable;
		logic       strip_syn;
		logic       strip_dle;
		logic       ext_1x;
		logic [1:0] rate_idx;
		logic [1:0] rate_div_log2;
		logic       rx_rate1;
	} ulfc_cfg_t;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} ulfc_avs_req_t;

endpackage : ulfc_pkg

// ==== core/ulfc_line_format_control.sv ====
// Line format and modem link configuration decode with Avalon-MM register slave.
`timescale 1ns/10ps
module ulfc_line_format_control
	import ulfc_pkg::*;
(
	// Clock and reset.
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	// Avalon-MM slave.
	input  wire ulfc_pkg::ulfc_avs_req_t avs_req,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	// Modem pins.
	input  wire logic                   cts_n,
	output logic                        rts_n,
	output logic                        dtr_n,
	output logic                        misc_n,
	// Character stream from the receiver engine.
	input  wire logic                   char_boundary,
	input  wire logic                   rx_char_valid,
	input  wire logic [7:0]             rx_char_data,
	// Characters passed on to software, and active configuration.
	output logic                        rx_out_valid,
	output logic [7:0]                  rx_out_data,
	output ulfc_pkg::ulfc_cfg_t         cfg_active,
	// Interrupt.
	output logic                        irq
);
	import ulfc_pkg::*;

	// Number of data bits for a length code.
	function automatic logic [3:0] len_bits(input logic [1:0] code);
		len_bits = 4'h8 - {2'h0, code};
	endfunction : len_bits

	// Mask covering the valid data bits of a character.
	function automatic logic [7:0] len_mask(input logic [1:0] code);
		len_mask = 8'hFF >> code;
	endfunction : len_mask

	logic [7:0]    lfc_ff, nxt_lfc;
	logic [7:0]    mlc_ff, nxt_mlc;
	logic [7:0]    syn_ff, nxt_syn;
	logic [7:0]    dle_ff, nxt_dle;
	logic [1:0]    status_ff, nxt_status;
	logic [1:0]    mask_ff, nxt_mask;
	logic [7:0]    rxdata_ff, nxt_rxdata;
	logic          wait_ff, nxt_wait;
	logic [31:0]   rdata_ff, nxt_rdata;
	logic          cts_meta_ff, cts_sync_ff;
	ulfc_cfg_t     cfg_ff, nxt_cfg;
	ulfc_cfg_t     cfg_dec;
	logic          syn_pend_ff, nxt_syn_pend;
	logic          rxv_ff, nxt_rxv;
	logic [7:0]    rxo_ff, nxt_rxo;
	logic          rts_ff, dtr_ff, misc_ff, irq_ff;

	// One select per mapped word, shared by reads and writes so the two maps cannot drift.
	wire           sel_lfc  = (avs_req.address == ULFC_OFF_LFC);
	wire           sel_mlc  = (avs_req.address == ULFC_OFF_MLC);
	wire           sel_syn  = (avs_req.address == ULFC_OFF_SYN);
	wire           sel_dle  = (avs_req.address == ULFC_OFF_DLE);
	wire           sel_stat = (avs_req.address == ULFC_OFF_STATUS);
	wire           sel_mask = (avs_req.address == ULFC_OFF_MASK);
	wire           sel_rxd  = (avs_req.address == ULFC_OFF_RXDATA);

	// Bus decode: an access completes at the edge where waitrequest is low.
	// Only byte lane 0 carries register bits, so a write without it changes nothing.
	wire           req      = avs_req.read | avs_req.write;
	wire           done     = req & ~wait_ff;
	wire           wr_lane0 = done & avs_req.write & avs_req.byteenable[0];
	wire [7:0]     wd       = avs_req.writedata[7:0];
	wire           wr_lfc   = wr_lane0 & sel_lfc;
	wire           wr_mlc   = wr_lane0 & sel_mlc;
	wire           wr_syn   = wr_lane0 & sel_syn;
	wire           wr_dle   = wr_lane0 & sel_dle;
	wire           wr_stat  = wr_lane0 & sel_stat;
	wire           wr_mask  = wr_lane0 & sel_mask;

	// Read mux; unmapped addresses read as zero and ignore writes.
	// It settles while waitrequest is high, so readdata is registered before it is taken.
	wire [7:0]     rd_byte =
		sel_lfc  ? lfc_ff :
		sel_mlc  ? mlc_ff :
		sel_syn  ? syn_ff :
		sel_dle  ? dle_ff :
		sel_stat ? {6'h00, status_ff} :
		sel_mask ? {6'h00, mask_ff} :
		sel_rxd  ? rxdata_ff : 8'h00;

	// One wait cycle per access, then the answer for exactly one edge.
	// A request dropped before its answer leaves the slave idle and changes nothing.
	assign nxt_wait  = ~(req & wait_ff);
	assign nxt_rdata = (req & wait_ff & avs_req.read) ? {24'h000000, rd_byte} : rdata_ff;

	// Registers keep their value until software writes them again.
	assign nxt_lfc  = wr_lfc ? wd : lfc_ff;
	assign nxt_mlc  = wr_mlc ? wd : mlc_ff;
	assign nxt_syn  = wr_syn ? wd : syn_ff;
	assign nxt_dle  = wr_dle ? wd : dle_ff;
	assign nxt_mask = wr_mask ? wd[1:0] : mask_ff;

	// Field views of the two control registers.
	wire           f_sync   = lfc_ff[ULFC_LFC_SYNC];
	wire           f_rxclk  = lfc_ff[ULFC_LFC_RXCLK];
	wire [2:0]     f_clk    = lfc_ff[ULFC_LFC_CLK_LO +: 3];
	wire [1:0]     f_len    = lfc_ff[ULFC_LFC_LEN_LO +: 2];
	wire           f_rxen   = mlc_ff[ULFC_MLC_RXEN];
	wire           f_par    = mlc_ff[ULFC_MLC_PAR];
	wire           f_b4     = mlc_ff[ULFC_MLC_ECHO];
	wire           f_b5     = mlc_ff[ULFC_MLC_STOP];
	wire           f_b6     = mlc_ff[ULFC_MLC_TRANSP];
	wire           f_normal = mlc_ff[ULFC_MLC_NORMAL];
	// Transmitter runs only while asked to send and the modem clears it; loop feeds RTS back.
	wire           cts_ok   = f_normal ? ~cts_sync_ff : 1'b1;
	wire           tx_en    = mlc_ff[ULFC_MLC_RTS] & cts_ok;

	// Decode of the written registers into the engine configuration.
	always_comb
	begin
		cfg_dec               = '0;
		// Character framing and operating mode.
		cfg_dec.data_bits     = len_bits(f_len);
		cfg_dec.sync_mode     = f_sync;
		cfg_dec.loop_mode     = ~f_normal;
		// Parity: synchronous mode splits generation and checking over two bits.
		cfg_dec.parity_odd    = f_par | f_b5 ? lfc_ff[ULFC_LFC_ODD] : 1'b0;
		cfg_dec.tx_parity_en  = f_sync ? (f_b5 & ~f_b6) : f_par;
		cfg_dec.rx_parity_en  = f_sync ? (f_par & ~(f_rxen & f_b4)) : f_par;
		// Transmit options; the stop bit choice only matters to the asynchronous framer.
		cfg_dec.stop_sel      = f_b5 ? ULFC_STOP_ONE :
			(f_len == 2'h3 ? ULFC_STOP_ONE_HALF : ULFC_STOP_TWO);
		cfg_dec.transparent   = f_sync & f_b6;
		cfg_dec.force_dle     = f_sync & f_b6 & f_b5;
		cfg_dec.tx_break      = ~f_sync & tx_en & f_b6;
		cfg_dec.echo          = ~f_sync & f_rxen & f_b4;
		cfg_dec.rx_enable     = f_rxen;
		// Receive stripping acts in synchronous mode only.
		cfg_dec.strip_syn     = f_sync & f_rxclk;
		cfg_dec.strip_dle     = f_sync & ((f_rxclk & f_b6) | (f_rxen & f_b4));
		// Clock choice shared by both engines.
		cfg_dec.ext_1x        = (f_clk == ULFC_CLK_EXT1X);
		cfg_dec.rate_idx      = (f_clk >= ULFC_CLK_DIV2 || f_clk == ULFC_CLK_EXT1X) ?
			2'h3 : 2'(f_clk - 3'h1);
		cfg_dec.rate_div_log2 = (f_clk >= ULFC_CLK_DIV2) ? 2'(f_clk - 3'h4) : 2'h0;
		// The 1X choice is only valid with bit 3 set; software must keep that pairing.
		cfg_dec.rx_rate1      = ~f_sync & ~f_rxclk & (f_clk != ULFC_CLK_EXT1X);
	end

	// New settings reach the engines at the next character boundary, never mid-character.
	assign nxt_cfg = char_boundary ? cfg_dec : cfg_ff;

	// Receive path: strip matched SYN/DLE and flag SYN detect on the next kept character.
	// The compare is masked to the character length, so stale high bits of a longer
	// setting can never stop a short SYN or DLE from being stripped.
	wire [7:0]     rx_m     = rx_char_data & len_mask(f_len);
	wire           is_syn   = rx_m == (syn_ff & len_mask(f_len));
	wire           is_dle   = rx_m == (dle_ff & len_mask(f_len));
	wire           rx_take  = rx_char_valid & cfg_ff.rx_enable;
	wire           strip    = rx_take & ((cfg_ff.strip_syn & is_syn) |
		(cfg_ff.strip_dle & is_dle));
	wire           keep     = rx_take & ~strip;
	wire           ev_syn   = keep & syn_pend_ff;

	assign nxt_syn_pend = strip | (syn_pend_ff & ~keep);
	assign nxt_rxv      = keep;
	assign nxt_rxo      = keep ? rx_char_data : rxo_ff;
	assign nxt_rxdata   = keep ? rx_char_data : rxdata_ff;

	// Sticky status: a new event wins over a clear in the same cycle.
	// The mask only gates the interrupt; status records every event regardless.
	wire [1:0]     ev_vec   = {ev_syn, keep & ~syn_pend_ff};
	wire [1:0]     clr_vec  = wr_stat ? wd[1:0] : 2'h0;
	assign nxt_status = (status_ff & ~clr_vec) | ev_vec;

	// Modem outputs are held off in loop mode; MISC goes low for its two auxiliary cases.
	// Loop mode is a diagnostic state, so the modem must see every pin in its off state.
	wire           misc_on  = (f_sync & ~f_rxen & f_b4) | (~f_sync & ~tx_en & f_b5);
	wire           nxt_rtsn = ~(f_normal & mlc_ff[ULFC_MLC_RTS]);
	wire           nxt_dtrn = ~(f_normal & mlc_ff[ULFC_MLC_DTR]);
	wire           nxt_misc = ~(f_normal & misc_on);
	wire           nxt_irq  = |(nxt_status & nxt_mask);

	// Clear-to-send synchroniser; only the second stage is used.
	// Both stages reset to the inactive level so no false clear follows reset.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cts_meta_ff <= 1'b1;
			cts_sync_ff <= 1'b1;
		end
		else
		begin
			cts_meta_ff <= cts_n;
			cts_sync_ff <= cts_meta_ff;
		end
	end

	// Control and character registers written by software.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			lfc_ff    <= ULFC_RST_LFC;
			mlc_ff    <= ULFC_RST_MLC;
			syn_ff    <= ULFC_RST_SYN;
			dle_ff    <= ULFC_RST_DLE;
		end
		else
		begin
			lfc_ff    <= nxt_lfc;
			mlc_ff    <= nxt_mlc;
			syn_ff    <= nxt_syn;
			dle_ff    <= nxt_dle;
		end
	end

	// Bus handshake, interrupt status and the last kept character.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			mask_ff   <= ULFC_RST_IRQ;
			status_ff <= ULFC_RST_IRQ;
			wait_ff   <= 1'b1;
			rdata_ff  <= '0;
			rxdata_ff <= '0;
		end
		else
		begin
			mask_ff   <= nxt_mask;
			status_ff <= nxt_status;
			wait_ff   <= nxt_wait;
			rdata_ff  <= nxt_rdata;
			rxdata_ff <= nxt_rxdata;
		end
	end

	// Active configuration and the receive output stage.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cfg_ff      <= '0;
			syn_pend_ff <= 1'b0;
			rxv_ff      <= 1'b0;
			rxo_ff      <= '0;
		end
		else
		begin
			cfg_ff      <= nxt_cfg;
			syn_pend_ff <= nxt_syn_pend;
			rxv_ff      <= nxt_rxv;
			rxo_ff      <= nxt_rxo;
		end
	end

	// Modem pins and the interrupt line.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			rts_ff      <= 1'b1;
			dtr_ff      <= 1'b1;
			misc_ff     <= 1'b1;
			irq_ff      <= 1'b0;
		end
		else
		begin
			rts_ff      <= nxt_rtsn;
			dtr_ff      <= nxt_dtrn;
			misc_ff     <= nxt_misc;
			irq_ff      <= nxt_irq;
		end
	end

	// Outputs come straight from flip-flops.
	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign rts_n           = rts_ff;
	assign dtr_n           = dtr_ff;
	assign misc_n          = misc_ff;
	assign rx_out_valid    = rxv_ff;
	assign rx_out_data     = rxo_ff;
	assign cfg_active      = cfg_ff;
	assign irq             = irq_ff;

endmodule : ulfc_line_format_control

// ==== testbench/ulfc_monitor.sv ====
// Port checker for the line format block.
`timescale 1ns/10ps
module ulfc_monitor
	import ulfc_pkg::*;
(
	// Clock and reset.
	input wire logic                    clk_sys,
	input wire logic                    reset,
	// Bus and character stream.
	input wire ulfc_pkg::ulfc_avs_req_t avs_req,
	input wire logic                    avs_waitrequest,
	input wire logic                    char_boundary,
	input wire logic                    rx_char_valid,
	input wire logic [7:0]              rx_char_data,
	input wire logic                    rx_out_valid,
	input wire logic [7:0]              rx_out_data,
	input wire ulfc_pkg::ulfc_cfg_t     cfg_active
);
	// All checks share the one system clock and its reset.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	a_bus_answer: assert property ((avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus access not answered");
	a_cfg_hold: assert property (!char_boundary |=> $stable(cfg_active)) else $error("config moved off a boundary");
	a_kept_source: assert property (rx_out_valid |-> $past(rx_char_valid) && $past(cfg_active.rx_enable) && rx_out_data == $past(rx_char_data)) else $error("kept char has no cause");
	a_syn_strip: assert property (rx_char_valid && cfg_active.rx_enable && cfg_active.sync_mode && cfg_active.strip_syn && rx_char_data == ULFC_RST_SYN |=> !rx_out_valid) else $error("SYN char passed");
	a_dle_strip: assert property (rx_char_valid && cfg_active.rx_enable && cfg_active.sync_mode && cfg_active.strip_dle && rx_char_data == ULFC_RST_DLE |=> !rx_out_valid) else $error("DLE char passed");
	a_async_parity: assert property (!cfg_active.sync_mode |-> cfg_active.tx_parity_en == cfg_active.rx_parity_en) else $error("async parity split");
	a_transp_parity: assert property (cfg_active.sync_mode && cfg_active.transparent |-> !cfg_active.tx_parity_en) else $error("parity in transparent mode");
	a_half_stop: assert property (cfg_active.stop_sel == ULFC_STOP_ONE_HALF |-> cfg_active.data_bits == 4'h5) else $error("half stop on long char");
endmodule : ulfc_monitor

// ==== testbench/ulfc_modem_model.sv ====
// Data set model: clear-to-send answer and the assembled character stream.
`timescale 1ns/10ps
module ulfc_modem_model
(
	// Clock and handshake.
	input wire logic   clk_sys,
	input wire logic   rts_n,
	input wire logic   slow,
	// Lines toward the block.
	output logic       cts_n,
	output logic       char_boundary,
	output logic       rx_char_valid,
	output logic [7:0] rx_char_data
);
	logic [7:0] rts_hist_ff = 8'hFF;

	// Clear to send follows the request after a short or a long delay.
	always @(posedge clk_sys) rts_hist_ff <= {rts_hist_ff[6:0], rts_n};
	assign cts_n = slow ? rts_hist_ff[5] : rts_hist_ff[0];
	initial char_boundary = 1'b0;
	initial rx_char_valid = 1'b0;
	initial rx_char_data = 8'h00;

	// One character; idle data is inverted so nothing can lean on a stale byte.
	task automatic send(input logic [7:0] d);
		rx_char_valid <= 1'b1;
		rx_char_data <= d;
		@(posedge clk_sys);
		rx_char_valid <= 1'b0;
		rx_char_data <= ~d;
		@(posedge clk_sys);
	endtask : send

	// Character boundary pulse, one cycle.
	task automatic bound();
		char_boundary <= 1'b1;
		@(posedge clk_sys);
		char_boundary <= 1'b0;
	endtask : bound
endmodule : ulfc_modem_model

// ==== testbench/ulfc_line_format_control_tb.sv ====
// Self-checking bench for the line format block.
`timescale 1ns/10ps
module ulfc_line_format_control_tb;
	import ulfc_pkg::*;
	logic clk_sys, reset, slow, cts_n, char_boundary, rx_char_valid, avs_waitrequest;
	logic rts_n, dtr_n, misc_n, rx_out_valid, irq;
	logic [7:0] rx_char_data, rx_out_data, d;
	logic [31:0] avs_readdata;
	ulfc_avs_req_t req;
	ulfc_cfg_t cfg_active;
	logic [7:0] exp_rx[$];
	logic [31:0] exp_rd[$];
	int fails, total_checks, seed, i;

	ulfc_line_format_control ulfc_line_format_control_i (.clk_sys(clk_sys), .reset(reset),
		.avs_req(req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n), .misc_n(misc_n),
		.char_boundary(char_boundary), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .cfg_active(cfg_active), .irq(irq));
	ulfc_modem_model ulfc_modem_model_i (.clk_sys(clk_sys), .rts_n(rts_n), .slow(slow),
		.cts_n(cts_n), .char_boundary(char_boundary), .rx_char_valid(rx_char_valid),
		.rx_char_data(rx_char_data));

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// One Avalon access; the request stands until waitrequest is seen low.
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v, input logic [3:0] be);
		int n;
		req <= '{~w, w, a, be, {24'h0, v}};
		for (n = 0; n < 16; n++)
		begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (n == 16)
			chk("bus_timeout", 0, 1);
		if (n == 16)
			print_verdict();
		req <= '0;
		@(posedge clk_sys);
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		bus(1'b1, a, v, 4'hF);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		exp_rd.push_back({24'h0, e});
		bus(1'b0, a, 8'h00, 4'hF);
	endtask : rd

	// Write both controls; the decode must not move until the boundary pulse.
	task automatic cf(input logic [7:0] l, input logic [7:0] m);
		ulfc_cfg_t c0;
		c0 = cfg_active;
		wr(ULFC_OFF_LFC, l);
		wr(ULFC_OFF_MLC, m);
		chk("cfg_hold", c0, cfg_active);
		ulfc_modem_model_i.bound();
		@(posedge clk_sys);
	endtask : cf

	task automatic ch(input logic [7:0] v, input logic keep);
		if (keep)
			exp_rx.push_back(v);
		ulfc_modem_model_i.send(v);
	endtask : ch

	task automatic pins(input logic [2:0] e);
		int n;
		for (n = 0; n < 16 && {rts_n, dtr_n, misc_n} !== e; n++)
			@(posedge clk_sys);
		chk("pins", e, {rts_n, dtr_n, misc_n});
	endtask : pins

	// Output watcher: each completed read and kept char takes the oldest note.
	always @(posedge clk_sys)
	begin
		if (req.read && avs_waitrequest === 1'b0)
			chk("readdata", exp_rd.size() ? exp_rd.pop_front() : 32'hFFFFFFFF, avs_readdata);
		if (rx_out_valid === 1'b1)
			chk("rx_out_data", exp_rx.size() ? exp_rx.pop_front() : 32'h100, rx_out_data);
	end

	initial
	begin
		seed = 17;
		reset = 1'b1;
		slow = 1'b0;
		req = '0;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(ULFC_OFF_LFC, ULFC_RST_LFC);
		rd(ULFC_OFF_MLC, ULFC_RST_MLC);
		rd(ULFC_OFF_SYN, ULFC_RST_SYN);
		rd(ULFC_OFF_DLE, ULFC_RST_DLE);
		rd(ULFC_OFF_STATUS, 8'h00);
		rd(5'h1C, 8'h00);
		d = 8'($random(seed));
		wr(ULFC_OFF_MLC, d);
		bus(1'b1, ULFC_OFF_MLC, ~d, 4'h0);
		rd(ULFC_OFF_MLC, d);
		$display("test registers done");
		for (i = 0; i < 4; i++)
		begin
			cf({i[1:0], 6'h08}, 8'h80);
			chk("data_bits", 8 - i, cfg_active.data_bits);
		end
		for (i = 0; i < 8; i++)
		begin
			cf({5'h01, i[2:0]}, 8'h80);
			chk("ext_1x", i == 0, cfg_active.ext_1x);
			chk("rate_idx", (i == 0 || i > 4) ? 3 : i - 1, cfg_active.rate_idx);
			chk("rate_div", i > 4 ? i - 4 : 0, cfg_active.rate_div_log2);
		end
		cf(8'h18, 8'h88);
		chk("sync", 0, cfg_active.sync_mode);
		chk("tx_par", 1, cfg_active.tx_parity_en);
		chk("rx_par", 1, cfg_active.rx_parity_en);
		chk("odd", 1, cfg_active.parity_odd);
		cf(8'h28, 8'h88);
		chk("sync", 1, cfg_active.sync_mode);
		chk("tx_par", 0, cfg_active.tx_parity_en);
		chk("rx_par", 1, cfg_active.rx_parity_en);
		chk("odd", 0, cfg_active.parity_odd);
		cf(8'h38, 8'hA0);
		chk("tx_par", 1, cfg_active.tx_parity_en);
		chk("odd", 1, cfg_active.parity_odd);
		cf(8'h28, 8'hE0);
		chk("tx_par", 0, cfg_active.tx_parity_en);
		chk("transp", 1, cfg_active.transparent);
		chk("force_dle", 1, cfg_active.force_dle);
		cf(8'hC8, 8'h82);
		chk("stop", ULFC_STOP_ONE_HALF, cfg_active.stop_sel);
		cf(8'h08, 8'h82);
		chk("stop", ULFC_STOP_TWO, cfg_active.stop_sel);
		cf(8'h08, 8'hA2);
		chk("stop", ULFC_STOP_ONE, cfg_active.stop_sel);
		pins(3'b011);
		slow <= 1'b1;
		wr(ULFC_OFF_MLC, 8'hA0);
		pins(3'b110);
		wr(ULFC_OFF_MLC, 8'hA3);
		pins(3'b001);
		wr(ULFC_OFF_MLC, 8'h23);
		pins(3'b111);
		$display("test decode done");
		cf(8'h28, 8'h84);
		wr(ULFC_OFF_MASK, 8'h02);
		ch(8'h16, 1'b0);
		ch(8'h10, 1'b1);
		chk("irq", 1, irq);
		rd(ULFC_OFF_STATUS, 8'h02);
		wr(ULFC_OFF_STATUS, 8'h02);
		chk("irq", 0, irq);
		d = {1'b1, 7'($random(seed))};
		ch(d, 1'b1);
		chk("irq", 0, irq);
		rd(ULFC_OFF_STATUS, 8'h01);
		rd(ULFC_OFF_RXDATA, d);
		cf(8'h28, 8'hC4);
		ch(8'h10, 1'b0);
		ch(8'h16, 1'b0);
		ch(8'h55, 1'b1);
		cf(8'h08, 8'h84);
		chk("strip_syn", 0, cfg_active.strip_syn);
		ch(8'h16, 1'b1);
		cf(8'h28, 8'hC0);
		ch(8'h5A, 1'b0);
		chk("rx_left", 0, exp_rx.size());
		chk("rd_left", 0, exp_rd.size());
		$display("test stream done");
		print_verdict();
	end
endmodule : ulfc_line_format_control_tb

bind ulfc_line_format_control ulfc_monitor ulfc_monitor_i (.clk_sys(clk_sys), .reset(reset),
	.avs_req(avs_req), .avs_waitrequest(avs_waitrequest), .char_boundary(char_boundary),
	.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data), .rx_out_valid(rx_out_valid),
	.rx_out_data(rx_out_data), .cfg_active(cfg_active));
